// >>> hw/flash_seq_pkg.sv
// Shared constants and types for the flash command sequencer and its host controller.
// Assumes one clock, core_clk at 125 MHz, and a synchronous active-low reset.
// Summary of operation
// - Supply out of range sets status bit 3.
// - Failed program verify sets status bit 4.
// - Locked block target sets bit 1, aborts.
// - Only clear-status command clears bits 1,3,4.
// - Host clears status before retrying after error.
// - Code 70h selects status read in partition.
// - B0h during program suspends it, any address.
// - Host suspends erase with B0h in partition.
// - Status output refreshes only on new read; status_word port refreshes each cycle.
// - Status bit 7 shows engine ready or busy.
// - Bit 2 shows program suspended, else completed.
// - Bit 6 shows erase suspended, else completed.
// - Program suspended: read other blocks after FFh.
// - Erase suspended: read or program other blocks.
// - D0h at suspended block resumes the program.
// - D0h at any address resumes the erase.
// - Protection program: C0h setup, then data write.
// - Protection address out of space gives error.
// - Host checks errors per program or batch.
// - Host writes FFh after last program.
// - Only one program or erase active.
// - Each partition keeps its read mode.
// - Engine decisions ignore partition read modes.
`default_nettype none

package flash_seq_pkg;
  // Bus and array geometry.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int NUM_PART = 4;
  localparam int PART_LSB = 4;
  localparam int BLK_LSB = 3;
  localparam int NUM_BLK = 8;
  localparam int ARR_WORDS = 64;
  localparam int OTP_WORDS = 4;
  localparam int OTP_IDX_W = 2;
  // Command codes carried in the low byte of a write.
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_OTP = 8'hC0;
  // Status word bit positions.
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_VPP_ERR = 3;
  localparam int SR_PROG_SUSP = 2;
  localparam int SR_LOCK_ERR = 1;
  // Internal operation durations in core_clk cycles.
  localparam int CNT_W = 6;
  localparam logic [5:0] PROG_CYCLES = 6'h08;
  localparam logic [5:0] ERASE_CYCLES = 6'h20;
  // Status word shown after reset: engine ready, no flags.
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // Identifier and query answers; the values are arbitrary.
  localparam logic [15:0] ID_WORD = 16'h0A5A;
  localparam logic [15:0] QUERY_WORD = 16'h00C3;
  // Host controller register offsets and fields.
  localparam int SW_ADDR_W = 5;
  localparam logic [4:0] HREG_ADDR = 5'h00;
  localparam logic [4:0] HREG_DATA = 5'h04;
  localparam logic [4:0] HREG_GO = 5'h08;
  localparam logic [4:0] HREG_RESULT = 5'h0C;
  localparam logic [4:0] HREG_STAT = 5'h10;
  localparam int GO_WRITE = 0;
  localparam int GO_READ = 1;
  localparam int STAT_ERR_PEND = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_STATUS_MODE = 2;

  // Output mode of one partition.
  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0,
    MODE_ID = 2'h1,
    MODE_QUERY = 2'h2,
    MODE_STATUS = 2'h3
  } read_mode_t;

  // Write state engine activity.
  typedef enum logic [2:0] {
    ENG_READY = 3'h1,
    ENG_PROG = 3'h2,
    ENG_ERASE = 3'h4
  } eng_state_t;

  // Pending first half of a two-write command.
  typedef enum logic [3:0] {
    SET_NONE = 4'h1,
    SET_PROG = 4'h2,
    SET_ERASE = 4'h4,
    SET_OTP = 4'h8
  } setup_t;
endpackage : flash_seq_pkg

`default_nettype wire

// >>> hw/flash_bus_if.sv
// Command and data bus between the flash controller and the flash sequencer.
// Assumes both ends run on core_clk; every strobe is one cycle long.
`default_nettype none

interface flash_bus_if;
  // Write strobe: wdata carries a command or program data for addr.
  logic wr_en;
  // Read strobe: the device answers on rdata in the next cycle.
  logic rd_en;
  // Word address; the top bits select partition and block.
  logic [flash_seq_pkg::ADDR_W-1:0] addr;
  // Write data.
  logic [flash_seq_pkg::DATA_W-1:0] wdata;
  // Read data, registered in the device.
  logic [flash_seq_pkg::DATA_W-1:0] rdata;

  modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata);
  modport host (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface : flash_bus_if

`default_nettype wire

// >>> hw/part_mode.sv
// Read-mode holder for one partition of the flash sequencer.
// Assumes set and mode come from logic on core_clk.
`default_nettype none

module part_mode (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic set,
  input wire flash_seq_pkg::read_mode_t mode,
  output flash_seq_pkg::read_mode_t mode_ff
);
  // The whole state of the holder.
  typedef struct packed {
    flash_seq_pkg::read_mode_t mode;
  } part_st_t;

  part_st_t st_ff;
  part_st_t nxt_st;

  // The mode changes only on a new command to this partition.
  always_comb begin
    nxt_st = st_ff;
    if (set) begin
      nxt_st.mode = mode;
    end
  end

  // Register the state; a partition starts in array mode.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff.mode <= flash_seq_pkg::MODE_ARRAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mode_ff = st_ff.mode;
endmodule : part_mode

`default_nettype wire

// >>> hw/flash_dev_end.sv
// Flash command sequencer: decodes bus commands, runs program, erase and
// protection-area program, handles suspend and resume and drives the status word.
// Assumes the bus comes from logic on core_clk and vpp_ok and lock_mask are
// same-clock levels.
`default_nettype none

module flash_dev_end (
  input wire logic core_clk,
  input wire logic rst_b,
  flash_bus_if.dev bus,
  input wire logic vpp_ok,
  input wire logic [flash_seq_pkg::NUM_BLK-1:0] lock_mask,
  output logic eng_ready,
  output logic [7:0] status_word
);
  // The whole state of the sequencer.
  typedef struct packed {
    flash_seq_pkg::eng_state_t eng;                                   // Engine activity.
    flash_seq_pkg::setup_t setup;                                     // First half of a command.
    logic [flash_seq_pkg::CNT_W-1:0] cnt;                             // Cycles left of the operation.
    logic [flash_seq_pkg::ADDR_W-1:0] op_addr;                        // Program target.
    logic [flash_seq_pkg::DATA_W-1:0] op_data;                        // Program data.
    logic op_otp;                                                     // Program goes to protection area.
    logic [flash_seq_pkg::ADDR_W-1:0] ers_addr;                       // Address inside erased block.
    logic prog_susp;                                                  // Program is suspended.
    logic erase_susp;                                                 // Erase is suspended.
    logic err_vpp;                                                    // Supply error flag.
    logic err_prog;                                                   // Program error flag.
    logic err_lock;                                                   // Locked block flag.
    logic ready;                                                      // Copy of engine ready.
    logic [7:0] status;                                               // Copy of the status word.
    logic [flash_seq_pkg::DATA_W-1:0] rdata;                          // Read answer.
    logic [flash_seq_pkg::OTP_WORDS-1:0][flash_seq_pkg::DATA_W-1:0] otp;  // Protection area.
    logic [flash_seq_pkg::ARR_WORDS-1:0][flash_seq_pkg::DATA_W-1:0] arr;  // Main array.
  } dev_t;

  dev_t dev_ff;
  dev_t nxt_dev;

  // Per-partition mode update strobes and the mode to load.
  logic [flash_seq_pkg::NUM_PART-1:0] mode_set;
  flash_seq_pkg::read_mode_t mode_val;
  flash_seq_pkg::read_mode_t part_mode_q [flash_seq_pkg::NUM_PART];

  // One mode holder for each partition.
  for (genvar p = 0; p < flash_seq_pkg::NUM_PART; p++) begin : g_part
    part_mode u_mode (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .set(mode_set[p]),
      .mode(mode_val),
      .mode_ff(part_mode_q[p])
    );
  end

  // Status word built from live state.
  logic [7:0] sr_now;
  always_comb begin
    sr_now = 8'h00;
    sr_now[flash_seq_pkg::SR_READY] = (dev_ff.eng == flash_seq_pkg::ENG_READY);
    sr_now[flash_seq_pkg::SR_ERASE_SUSP] = dev_ff.erase_susp;
    sr_now[flash_seq_pkg::SR_PROG_ERR] = dev_ff.err_prog;
    sr_now[flash_seq_pkg::SR_VPP_ERR] = dev_ff.err_vpp;
    sr_now[flash_seq_pkg::SR_PROG_SUSP] = dev_ff.prog_susp;
    sr_now[flash_seq_pkg::SR_LOCK_ERR] = dev_ff.err_lock;
  end

  // Decoded fields of the current bus write.
  logic [7:0] cmd;
  logic [1:0] part;
  logic [2:0] blk;
  assign cmd = bus.wdata[7:0];
  assign part = bus.addr[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::PART_LSB];
  assign blk = bus.addr[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::BLK_LSB];

  // Next state: clear, engine step, command decode, read answer.
  always_comb begin
    logic [flash_seq_pkg::DATA_W-1:0] merged;
    logic idle_cmd;
    nxt_dev = dev_ff;
    mode_set = '0;
    mode_val = flash_seq_pkg::MODE_ARRAY;
    merged = '0;
    idle_cmd = bus.wr_en && (dev_ff.setup == flash_seq_pkg::SET_NONE);
    // Clearing goes first so that an error raised this cycle survives it.
    if (idle_cmd && cmd == flash_seq_pkg::CMD_CLEAR) begin
      nxt_dev.err_vpp = 1'b0;
      nxt_dev.err_prog = 1'b0;
      nxt_dev.err_lock = 1'b0;
    end
    // The engine advances on its own state only, never on any read mode.
    unique case (dev_ff.eng)
      flash_seq_pkg::ENG_PROG: begin
        if (dev_ff.cnt == '0) begin
          // Programming only clears bits, so a 1 over a 0 fails verify.
          if (dev_ff.op_otp) begin
            merged = dev_ff.otp[dev_ff.op_addr[flash_seq_pkg::OTP_IDX_W-1:0]] & dev_ff.op_data;
            nxt_dev.otp[dev_ff.op_addr[flash_seq_pkg::OTP_IDX_W-1:0]] = merged;
          end else begin
            merged = dev_ff.arr[dev_ff.op_addr] & dev_ff.op_data;
            nxt_dev.arr[dev_ff.op_addr] = merged;
          end
          if (merged != dev_ff.op_data) begin
            nxt_dev.err_prog = 1'b1;
          end
          nxt_dev.eng = flash_seq_pkg::ENG_READY;
        end else begin
          nxt_dev.cnt = dev_ff.cnt - 1'b1;
        end
      end
      flash_seq_pkg::ENG_ERASE: begin
        if (dev_ff.cnt == '0) begin
          for (int w = 0; w < flash_seq_pkg::ARR_WORDS; w++) begin
            if ((flash_seq_pkg::ADDR_W'(w) >> flash_seq_pkg::BLK_LSB) ==
                (dev_ff.ers_addr >> flash_seq_pkg::BLK_LSB)) begin
              nxt_dev.arr[w] = '1;
            end
          end
          nxt_dev.eng = flash_seq_pkg::ENG_READY;
        end else begin
          nxt_dev.cnt = dev_ff.cnt - 1'b1;
        end
      end
      flash_seq_pkg::ENG_READY: begin
        nxt_dev.eng = flash_seq_pkg::ENG_READY;
      end
      default: begin
        nxt_dev.eng = flash_seq_pkg::ENG_READY;
      end
    endcase
    // Second write of a two-write command.
    if (bus.wr_en && dev_ff.setup != flash_seq_pkg::SET_NONE) begin
      nxt_dev.setup = flash_seq_pkg::SET_NONE;
      if (dev_ff.setup == flash_seq_pkg::SET_OTP &&
          bus.addr >= flash_seq_pkg::ADDR_W'(flash_seq_pkg::OTP_WORDS)) begin
        nxt_dev.err_prog = 1'b1;
      end else if (dev_ff.setup == flash_seq_pkg::SET_ERASE && cmd != flash_seq_pkg::CMD_CONFIRM) begin
        // A setup without confirm is dropped with no effect.
        nxt_dev.setup = flash_seq_pkg::SET_NONE;
      end else if (!vpp_ok) begin
        nxt_dev.err_vpp = 1'b1;
      end else if (dev_ff.setup != flash_seq_pkg::SET_OTP && lock_mask[blk]) begin
        nxt_dev.err_lock = 1'b1;
      end else if (dev_ff.setup == flash_seq_pkg::SET_ERASE) begin
        nxt_dev.eng = flash_seq_pkg::ENG_ERASE;
        nxt_dev.ers_addr = bus.addr;
        nxt_dev.cnt = flash_seq_pkg::ERASE_CYCLES - 1'b1;
      end else begin
        nxt_dev.eng = flash_seq_pkg::ENG_PROG;
        nxt_dev.op_addr = bus.addr;
        nxt_dev.op_data = bus.wdata;
        nxt_dev.op_otp = (dev_ff.setup == flash_seq_pkg::SET_OTP);
        nxt_dev.cnt = flash_seq_pkg::PROG_CYCLES - 1'b1;
      end
    end else if (idle_cmd) begin
      unique case (cmd)
        flash_seq_pkg::CMD_READ_ARRAY: begin
          mode_set[part] = 1'b1;
          mode_val = flash_seq_pkg::MODE_ARRAY;
        end
        flash_seq_pkg::CMD_STATUS: begin
          mode_set[part] = 1'b1;
          mode_val = flash_seq_pkg::MODE_STATUS;
        end
        flash_seq_pkg::CMD_ID: begin
          mode_set[part] = 1'b1;
          mode_val = flash_seq_pkg::MODE_ID;
        end
        flash_seq_pkg::CMD_QUERY: begin
          mode_set[part] = 1'b1;
          mode_val = flash_seq_pkg::MODE_QUERY;
        end
        flash_seq_pkg::CMD_PROG, flash_seq_pkg::CMD_PROG_ALT, flash_seq_pkg::CMD_OTP: begin
          // A 40h or 10h program may start during an erase suspend, never beside a live operation.
          if (nxt_dev.eng == flash_seq_pkg::ENG_READY && !dev_ff.prog_susp &&
              !(cmd == flash_seq_pkg::CMD_OTP && dev_ff.erase_susp)) begin
            nxt_dev.setup = (cmd == flash_seq_pkg::CMD_OTP) ? flash_seq_pkg::SET_OTP
                                                             : flash_seq_pkg::SET_PROG;
            mode_set[part] = 1'b1;
            mode_val = flash_seq_pkg::MODE_STATUS;
          end
        end
        flash_seq_pkg::CMD_ERASE: begin
          if (nxt_dev.eng == flash_seq_pkg::ENG_READY && !dev_ff.prog_susp && !dev_ff.erase_susp) begin
            nxt_dev.setup = flash_seq_pkg::SET_ERASE;
            mode_set[part] = 1'b1;
            mode_val = flash_seq_pkg::MODE_STATUS;
          end
        end
        flash_seq_pkg::CMD_SUSPEND: begin
          // An operation finishing this cycle counts as completed, not suspended.
          if (nxt_dev.eng == flash_seq_pkg::ENG_PROG) begin
            nxt_dev.prog_susp = 1'b1;
            nxt_dev.eng = flash_seq_pkg::ENG_READY;
          end else if (nxt_dev.eng == flash_seq_pkg::ENG_ERASE) begin
            nxt_dev.erase_susp = 1'b1;
            nxt_dev.eng = flash_seq_pkg::ENG_READY;
          end
        end
        flash_seq_pkg::CMD_CONFIRM: begin
          // A suspended program resumes before a suspended erase.
          if (dev_ff.prog_susp) begin
            nxt_dev.prog_susp = 1'b0;
            nxt_dev.eng = flash_seq_pkg::ENG_PROG;
          end else if (dev_ff.erase_susp && nxt_dev.eng == flash_seq_pkg::ENG_READY) begin
            nxt_dev.erase_susp = 1'b0;
            nxt_dev.eng = flash_seq_pkg::ENG_ERASE;
          end
          // With nothing suspended the resume is ignored.
        end
        default: begin
          nxt_dev.setup = flash_seq_pkg::SET_NONE;
        end
      endcase
    end
    // A read latches one answer and holds it until the next read.
    if (bus.rd_en) begin
      unique case (part_mode_q[bus.addr[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::PART_LSB]])
        flash_seq_pkg::MODE_ARRAY: nxt_dev.rdata = dev_ff.arr[bus.addr];
        flash_seq_pkg::MODE_ID: begin
          nxt_dev.rdata = (bus.addr < flash_seq_pkg::ADDR_W'(flash_seq_pkg::OTP_WORDS))
                          ? dev_ff.otp[bus.addr[flash_seq_pkg::OTP_IDX_W-1:0]] : flash_seq_pkg::ID_WORD;
        end
        flash_seq_pkg::MODE_QUERY: nxt_dev.rdata = flash_seq_pkg::QUERY_WORD;
        flash_seq_pkg::MODE_STATUS: nxt_dev.rdata = {8'h00, sr_now};
        default: nxt_dev.rdata = '0;
      endcase
    end
    nxt_dev.ready = (nxt_dev.eng == flash_seq_pkg::ENG_READY);
    nxt_dev.status = sr_now;
  end

  // Register the state; the array and protection area start erased.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dev_ff <= '0;
      dev_ff.eng <= flash_seq_pkg::ENG_READY;
      dev_ff.setup <= flash_seq_pkg::SET_NONE;
      dev_ff.ready <= 1'b1;
      dev_ff.status <= flash_seq_pkg::STATUS_RESET;
      dev_ff.otp <= '1;
      dev_ff.arr <= '1;
    end else begin
      dev_ff <= nxt_dev;
    end
  end

  assign bus.rdata = dev_ff.rdata;
  assign eng_ready = dev_ff.ready;
  assign status_word = dev_ff.status;
endmodule : flash_dev_end

`default_nettype wire

// >>> hw/flash_host_end.sv
// Flash controller: turns software register accesses into single bus
// write and read cycles and watches status answers for error bits.
// Assumes the software port and the bus are both on core_clk.
`default_nettype none

module flash_host_end (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [flash_seq_pkg::SW_ADDR_W-1:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  flash_bus_if.host bus
);
  // The whole state of the controller.
  typedef struct packed {
    logic [flash_seq_pkg::ADDR_W-1:0] addr;  // Bus address register.
    logic [flash_seq_pkg::DATA_W-1:0] data;  // Bus write data register.
    logic wr;                                // Bus write strobe.
    logic rd;                                // Bus read strobe.
    logic cap;                               // Read answer arrives now.
    logic [flash_seq_pkg::DATA_W-1:0] result;  // Last read answer.
    logic stat_mode;                         // Last mode command selected status.
    logic err_pend;                          // Error seen, clear not yet sent.
    logic refused;                           // A setup was held back.
    logic [31:0] rdata;                      // Software read answer.
  } host_t;

  host_t h_ff;
  host_t nxt_h;

  // Next state of the controller.
  always_comb begin
    logic [7:0] c;
    c = h_ff.data[7:0];
    nxt_h = h_ff;
    nxt_h.wr = 1'b0;
    nxt_h.rd = 1'b0;
    nxt_h.cap = h_ff.rd;
    nxt_h.rdata = 32'h0000_0000;
    // A clear-status write just issued drops the pending error first.
    if (h_ff.wr && c == flash_seq_pkg::CMD_CLEAR) begin
      nxt_h.err_pend = 1'b0;
    end
    // Capture the answer and flag any error bit of a status read.
    if (h_ff.cap) begin
      nxt_h.result = bus.rdata;
      if (h_ff.stat_mode && (bus.rdata[flash_seq_pkg::SR_VPP_ERR] || bus.rdata[flash_seq_pkg::SR_PROG_ERR] ||
                             bus.rdata[flash_seq_pkg::SR_LOCK_ERR])) begin
        nxt_h.err_pend = 1'b1;
      end
    end
    // Track whether reads return status; setups switch the partition to status.
    if (h_ff.wr) begin
      unique case (c)
        flash_seq_pkg::CMD_STATUS, flash_seq_pkg::CMD_PROG, flash_seq_pkg::CMD_PROG_ALT,
        flash_seq_pkg::CMD_ERASE, flash_seq_pkg::CMD_OTP: nxt_h.stat_mode = 1'b1;
        flash_seq_pkg::CMD_READ_ARRAY, flash_seq_pkg::CMD_ID, flash_seq_pkg::CMD_QUERY: begin
          nxt_h.stat_mode = 1'b0;
        end
        default: nxt_h.stat_mode = h_ff.stat_mode;
      endcase
    end
    // Software writes.
    if (sw_wr) begin
      unique case (sw_addr)
        flash_seq_pkg::HREG_ADDR: nxt_h.addr = sw_wdata[flash_seq_pkg::ADDR_W-1:0];
        flash_seq_pkg::HREG_DATA: nxt_h.data = sw_wdata[flash_seq_pkg::DATA_W-1:0];
        flash_seq_pkg::HREG_GO: begin
          if (sw_wdata[flash_seq_pkg::GO_WRITE]) begin
            // No new setup goes out while an error waits for its clear.
            if (nxt_h.err_pend && (c == flash_seq_pkg::CMD_PROG || c == flash_seq_pkg::CMD_PROG_ALT ||
                                   c == flash_seq_pkg::CMD_ERASE || c == flash_seq_pkg::CMD_OTP)) begin
              nxt_h.refused = 1'b1;
            end else begin
              nxt_h.wr = 1'b1;
            end
          end else if (sw_wdata[flash_seq_pkg::GO_READ]) begin
            nxt_h.rd = 1'b1;
          end
        end
        flash_seq_pkg::HREG_STAT: begin
          if (sw_wdata[flash_seq_pkg::STAT_REFUSED]) begin
            nxt_h.refused = 1'b0;
          end
        end
        default: nxt_h.refused = nxt_h.refused;
      endcase
    end
    // Software reads answer in the next cycle only.
    if (sw_rd) begin
      unique case (sw_addr)
        flash_seq_pkg::HREG_ADDR: nxt_h.rdata = 32'(h_ff.addr);
        flash_seq_pkg::HREG_DATA: nxt_h.rdata = 32'(h_ff.data);
        flash_seq_pkg::HREG_RESULT: nxt_h.rdata = 32'(h_ff.result);
        flash_seq_pkg::HREG_STAT: nxt_h.rdata = 32'({h_ff.stat_mode, h_ff.refused, h_ff.err_pend});
        default: nxt_h.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register the state.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      h_ff <= '0;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign bus.wr_en = h_ff.wr;
  assign bus.rd_en = h_ff.rd;
  assign bus.addr = h_ff.addr;
  assign bus.wdata = h_ff.data;
  assign sw_rdata = h_ff.rdata;
endmodule : flash_host_end

`default_nettype wire

// >>> bench/flash_seq_asserts.sv
// Checker for the flash command bus and the sequencer's ready and status outputs.
// Assumes one clock domain; the bench instantiates it beside the bus interface.
`default_nettype none

module flash_seq_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [flash_seq_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_seq_pkg::DATA_W-1:0] wdata,
  input wire logic [flash_seq_pkg::DATA_W-1:0] rdata,
  input wire logic eng_ready,
  input wire logic [7:0] status_word
);
  // Bus writes of the clear, suspend and resume codes.
  wire logic clr = wr_en && wdata[7:0] == flash_seq_pkg::CMD_CLEAR;
  wire logic susp = wr_en && wdata[7:0] == flash_seq_pkg::CMD_SUSPEND;
  wire logic resm = wr_en && wdata[7:0] == flash_seq_pkg::CMD_CONFIRM;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_ready_bit: assert property (status_word[7] == $past(eng_ready))
    else $error("ready bit differs from engine");
  a_err_sticky: assert property (!clr && !$past(clr) |=>
    (status_word & $past(status_word) & 8'h1A) == ($past(status_word) & 8'h1A))
    else $error("error bit dropped without clear");
  a_err_clear: assert property (eng_ready && clr |=> ##1 (status_word & 8'h1A) == 8'h00)
    else $error("clear left an error bit");
  a_susp_ready: assert property (!eng_ready && susp |=> eng_ready)
    else $error("suspend did not free engine");
  a_resume_run: assert property (eng_ready && status_word[2] && !$past(wr_en) && resm |=> !eng_ready)
    else $error("resume did not restart program");
  a_idle_stays: assert property (eng_ready && !wr_en |=> eng_ready)
    else $error("engine started without a write");
  a_rdata_hold: assert property (!rd_en |=> $stable(rdata))
    else $error("read data changed without read");
  a_strobe_apart: assert property (!(wr_en && rd_en))
    else $error("both strobes high");
endmodule : flash_seq_asserts

`default_nettype wire

// >>> bench/flash_suspend_status_sequencer_bench.sv
// Bench joining controller and sequencer; drives the software port, vpp_ok and lock_mask.
// Assumes core_clk at 125 MHz and a synchronous active-low reset.
`default_nettype none

module flash_suspend_status_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, sw_wr, sw_rd, vpp_ok, eng_ready;
  logic [4:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, rd_val;
  logic [7:0] lock_mask, status_word;
  int err_total, samples_checked;

  flash_bus_if flash_bus_if_i ();
  flash_dev_end flash_dev_end_i (.core_clk(core_clk), .rst_b(rst_b), .bus(flash_bus_if_i.dev),
    .vpp_ok(vpp_ok), .lock_mask(lock_mask), .eng_ready(eng_ready), .status_word(status_word));
  flash_host_end flash_host_end_i (.core_clk(core_clk), .rst_b(rst_b), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(flash_bus_if_i.host));
  flash_seq_asserts flash_seq_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .wr_en(flash_bus_if_i.wr_en),
    .rd_en(flash_bus_if_i.rd_en), .addr(flash_bus_if_i.addr), .wdata(flash_bus_if_i.wdata),
    .rdata(flash_bus_if_i.rdata), .eng_ready(eng_ready), .status_word(status_word));

  // Free-running clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Prints the verdict and stops.
  task end_sim;
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // One software access; read data lands in rd_val.
  task sw(input logic [4:0] a, input logic [31:0] d, input logic w);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 rd_val = sw_rdata;
  endtask : sw

  // One bus write through the controller.
  task bw(input logic [5:0] a, input logic [15:0] d);
    sw(flash_seq_pkg::HREG_ADDR, {26'h0, a}, 1'b1);
    sw(flash_seq_pkg::HREG_DATA, {16'h0, d}, 1'b1);
    sw(flash_seq_pkg::HREG_GO, 32'h0000_0001, 1'b1);
  endtask : bw

  // One bus read through the controller, compared with the expected word.
  task br(input logic [5:0] a, input logic [15:0] exp);
    sw(flash_seq_pkg::HREG_ADDR, {26'h0, a}, 1'b1);
    sw(flash_seq_pkg::HREG_GO, 32'h0000_0002, 1'b1);
    repeat (3) @(posedge core_clk);
    sw(flash_seq_pkg::HREG_RESULT, 32'h0000_0000, 1'b0);
    samples_checked++;
    if (rd_val[15:0] !== exp) begin
      err_total++;
      $display("wrong value bus word at %h expected %h seen %h", a, exp, rd_val[15:0]);
    end
  endtask : br

  // One software register read, compared with the expected word.
  task hr(input logic [4:0] a, input logic [31:0] exp);
    sw(a, 32'h0000_0000, 1'b0);
    samples_checked++;
    if (rd_val !== exp) begin
      err_total++;
      $display("wrong value register %h expected %h seen %h", a, exp, rd_val);
    end
  endtask : hr

  // Bounded wait for the engine to become ready.
  task wait_rdy;
    int n;
    n = 0;
    // Sampled mid-cycle so that the ready flop has settled.
    repeat (2) @(negedge core_clk);
    while (eng_ready !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (eng_ready !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask : wait_rdy

  // Reset, then the command sequences.
  initial begin
    {rst_b, sw_wr, sw_rd, sw_addr, sw_wdata, err_total, samples_checked} = '0;
    vpp_ok = 1'b1;
    lock_mask = 8'h00;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    bw(6'h08, 16'h0040);
    bw(6'h08, 16'h1234);
    wait_rdy();
    bw(6'h08, 16'h0070);
    br(6'h08, 16'h0080);
    bw(6'h08, 16'h00FF);
    br(6'h08, 16'h1234);
    vpp_ok <= 1'b0;
    bw(6'h0B, 16'h0040);
    bw(6'h0B, 16'h0000);
    wait_rdy();
    bw(6'h0B, 16'h0070);
    br(6'h0B, 16'h0088);
    bw(6'h0B, 16'h0040);
    hr(flash_seq_pkg::HREG_STAT, 32'h0000_0007);
    bw(6'h0B, 16'h00FF);
    bw(6'h0B, 16'h0070);
    br(6'h0B, 16'h0088);
    bw(6'h0B, 16'h0050);
    br(6'h0B, 16'h0080);
    hr(flash_seq_pkg::HREG_STAT, 32'h0000_0006);
    vpp_ok <= 1'b1;
    lock_mask <= 8'h04;
    bw(6'h10, 16'h0040);
    bw(6'h10, 16'h5A5A);
    wait_rdy();
    bw(6'h10, 16'h0070);
    br(6'h10, 16'h0082);
    bw(6'h10, 16'h0050);
    br(6'h10, 16'h0080);
    lock_mask <= 8'h00;
    bw(6'h20, 16'h00C0);
    bw(6'h20, 16'h5555);
    wait_rdy();
    bw(6'h20, 16'h0070);
    br(6'h20, 16'h0090);
    bw(6'h20, 16'h0050);
    br(6'h20, 16'h0080);
    bw(6'h01, 16'h00C0);
    bw(6'h01, 16'h5555);
    wait_rdy();
    bw(6'h01, 16'h0090);
    br(6'h01, 16'h5555);
    bw(6'h08, 16'h0040);
    bw(6'h08, 16'h1235);
    wait_rdy();
    br(6'h08, 16'h0090);
    bw(6'h08, 16'h0050);
    bw(6'h18, 16'h0040);
    bw(6'h18, 16'h0000);
    wait_rdy();
    bw(6'h18, 16'h0020);
    bw(6'h18, 16'h00D0);
    bw(6'h18, 16'h00B0);
    bw(6'h18, 16'h0070);
    br(6'h18, 16'h00C0);
    bw(6'h08, 16'h00FF);
    br(6'h08, 16'h1234);
    bw(6'h08, 16'h00D0);
    wait_rdy();
    br(6'h18, 16'h0080);
    bw(6'h18, 16'h00FF);
    br(6'h18, 16'hFFFF);
    bw(6'h02, 16'h0040);
    bw(6'h02, 16'h00F0);
    bw(6'h02, 16'h00B0);
    bw(6'h02, 16'h0070);
    br(6'h02, 16'h0084);
    bw(6'h08, 16'h00FF);
    br(6'h08, 16'h1234);
    bw(6'h02, 16'h00D0);
    wait_rdy();
    br(6'h02, 16'h00F0);
    bw(6'h02, 16'h00D0);
    bw(6'h02, 16'h0070);
    br(6'h02, 16'h0080);
    end_sim();
  end
endmodule : flash_suspend_status_sequencer_bench

`default_nettype wire
